// file: common/spims_pkg.sv
// Package of the serial peripheral port: register map, field layouts, resets.
// Assumes an 8-bit register port on the core clock and byte-wide data.
package spims_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SPIMS_CTRL_ADDR = 8'hC3;
  localparam logic [7:0] SPIMS_STAT_ADDR = 8'hC4;
  localparam logic [7:0] SPIMS_DATA_ADDR = 8'hC5;
  localparam logic [7:0] SPIMS_ISTS_ADDR = 8'hC6;
  localparam logic [7:0] SPIMS_IMSK_ADDR = 8'hC7;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] SPIMS_CTRL_RST = 8'h00;
  localparam logic [7:0] SPIMS_DATA_RST = 8'h00;
  localparam logic [1:0] SPIMS_IRQ_RST = 2'h0;
  localparam int SPIMS_IRQ_DONE_BIT = 0;
  localparam int SPIMS_IRQ_MODE_FAULT_FLAG_BIT = 1;
  localparam logic [2:0] SPIMS_LAST_BIT = 3'h7;
  localparam logic [3:0] SPIMS_LAST_EDGE = 4'hF;

  // Control register layout, bit 7 first.
  typedef struct packed {
    logic port_enable_bit;
    logic master_select_bit;
    logic select_input_disable_bit;
    logic cpol;
    logic cpha;
    logic [2:0] rate;
  } spims_ctrl_t;

  // Status register layout, bit 7 first.
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic slave_select_error_flag;
    logic mode_fault_flag;
    logic [3:0] rsvd;
  } spims_stat_t;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } spims_bus_t;

  typedef enum logic {SPIMS_IDLE, SPIMS_RUN} spims_state_t;

endpackage

// file: hw/spims_core.sv
// Serial peripheral port working as master or slave, with its register file.
// Assumes a one-cycle register port on core_clk_i; pins arrive asynchronous.
`timescale 1ns/1ps
module spims_core (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire spims_pkg::spims_bus_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i,
  output logic tx_irq_req_o,
  output logic err_irq_req_o,
  output logic irq_o
);
  import spims_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  spims_ctrl_t ctrl_r;
  spims_state_t state_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic sck_prev_r;
  logic ss_prev_r;
  logic done_r;
  logic write_collision_flag_r;
  logic slave_select_error_flag_r;
  logic mode_fault_flag_r;
  logic arm_done_r;
  logic arm_write_collision_flag_r;
  logic arm_mode_fault_flag_r;
  logic [7:0] sreg_r;
  logic [7:0] rxbuf_r;
  logic out_r;
  logic [2:0] bit_cnt_r;
  logic [3:0] edge_cnt_r;
  logic [3:0] div_cnt_r;
  logic sck_r;
  logic sck_oe_r;
  logic miso_oe_r;
  logic [1:0] ists_r;
  logic [1:0] imsk_r;
  logic irq_r;
  logic tx_req_r;
  logic err_req_r;
  logic [7:0] rdata_r;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_s;
  logic wr_ctrl;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic wr_ists;
  logic wr_imsk;
  logic en;
  logic mst;
  logic slv;
  logic busy;
  logic mode_fault_flag_evt;
  logic m_tick;
  logic s_edge;
  logic lead;
  logic trail;
  logic capture;
  logic launch;
  logic in_bit;
  logic [7:0] cap_byte;
  logic byte_end;
  logic [7:0] end_byte;
  logic s_start;
  logic slave_select_error_flag_evt;
  spims_stat_t stat;

  // ****************************************
  // Pin synchronisers
  // ****************************************

  // Two flip-flops on every asynchronous pin input.
  // The clock bit resets low like its edge detector, so no false edge follows reset.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r <= 4'h7;
      sync2_r <= 4'h7;
    end else begin
      sync1_r <= {sck_i, mosi_i, miso_i, ss_n_i};
      sync2_r <= sync1_r;
    end
  end

  // Synchronised pin levels.
  assign sck_s = sync2_r[3];
  assign mosi_s = sync2_r[2];
  assign miso_s = sync2_r[1];
  assign ss_s = sync2_r[0];

  // Previous levels for edge detection.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_prev_r <= 1'b0;
      ss_prev_r <= 1'b1;
    end else begin
      sck_prev_r <= sck_s;
      ss_prev_r <= ss_s;
    end
  end

  // ****************************************
  // Register decode and events
  // ****************************************

  // Strobes per register.
  assign wr_ctrl = bus_i.we && (bus_i.addr == SPIMS_CTRL_ADDR);
  assign wr_data = bus_i.we && (bus_i.addr == SPIMS_DATA_ADDR);
  assign wr_ists = bus_i.we && (bus_i.addr == SPIMS_ISTS_ADDR);
  assign wr_imsk = bus_i.we && (bus_i.addr == SPIMS_IMSK_ADDR);
  assign rd_stat = bus_i.re && (bus_i.addr == SPIMS_STAT_ADDR);
  assign rd_data = bus_i.re && (bus_i.addr == SPIMS_DATA_ADDR);

  // Mode terms.
  assign en = ctrl_r.port_enable_bit;
  assign mst = en && ctrl_r.master_select_bit;
  assign slv = en && !ctrl_r.master_select_bit;
  assign busy = (state_r == SPIMS_RUN);
  assign mode_fault_flag_evt = mst && !ctrl_r.select_input_disable_bit && !ss_s;

  // Master clock tick and slave edges.
  assign m_tick = mst && busy && (div_cnt_r == 4'h0);
  assign s_edge = slv && !ss_s && (sck_s != sck_prev_r);
  assign lead = mst ? (m_tick && !edge_cnt_r[0]) : (s_edge && (sck_s != ctrl_r.cpol));
  assign trail = mst ? (m_tick && edge_cnt_r[0]) : (s_edge && (sck_s == ctrl_r.cpol));

  // Phase 0 captures on the leading edge, phase 1 on the trailing one.
  assign capture = ctrl_r.cpha ? trail : lead;
  assign launch = ctrl_r.cpha ? lead : trail;
  assign in_bit = mst ? miso_s : mosi_s;
  assign cap_byte = {sreg_r[6:0], in_bit};

  // Master ends after sixteen half periods, slave after eighth capture.
  assign byte_end = mst ? (m_tick && (edge_cnt_r == SPIMS_LAST_EDGE))
                        : (capture && (bit_cnt_r == SPIMS_LAST_BIT));
  assign end_byte = (mst && !ctrl_r.cpha) ? sreg_r : cap_byte;

  // Slave start: select fall in phase 0, first clock edge in phase 1.
  assign s_start = slv && !busy && !ss_s
                   && (ctrl_r.cpha ? lead : ss_prev_r);
  assign slave_select_error_flag_evt = slv && busy && ss_s && !ss_prev_r;

  // ****************************************
  // Control register
  // ****************************************

  // Software writes; a mode fault clears enable and master select.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= spims_ctrl_t'(SPIMS_CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= spims_ctrl_t'(bus_i.wdata);
      end
      if (mode_fault_flag_evt) begin
        ctrl_r.port_enable_bit <= 1'b0;
        ctrl_r.master_select_bit <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************

  // Done flag: status read arms the clear, data access clears; set wins.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_r <= 1'b0;
      arm_done_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        arm_done_r <= done_r;
      end else if (rd_data || wr_data) begin
        arm_done_r <= 1'b0;
      end
      if (byte_end) begin
        done_r <= 1'b1;
      end else if (arm_done_r && (rd_data || wr_data)) begin
        done_r <= 1'b0;
      end
    end
  end

  // Collision flag: data write while busy sets it, no request follows.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      write_collision_flag_r <= 1'b0;
      arm_write_collision_flag_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        arm_write_collision_flag_r <= write_collision_flag_r;
      end else if (rd_data || wr_data) begin
        arm_write_collision_flag_r <= 1'b0;
      end
      if (wr_data && busy) begin
        write_collision_flag_r <= 1'b1;
      end else if (arm_write_collision_flag_r && (rd_data || wr_data)) begin
        write_collision_flag_r <= 1'b0;
      end
    end
  end

  // Mode fault flag: status read seeing it arms, control write clears.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_fault_flag_r <= 1'b0;
      arm_mode_fault_flag_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        arm_mode_fault_flag_r <= mode_fault_flag_r;
      end else if (wr_ctrl) begin
        arm_mode_fault_flag_r <= 1'b0;
      end
      if (mode_fault_flag_evt) begin
        mode_fault_flag_r <= 1'b1;
      end else if (arm_mode_fault_flag_r && wr_ctrl) begin
        mode_fault_flag_r <= 1'b0;
      end
    end
  end

  // Select error: set on early select rise, cleared while disabled.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slave_select_error_flag_r <= 1'b0;
    end else if (slave_select_error_flag_evt) begin
      slave_select_error_flag_r <= 1'b1;
    end else if (!en) begin
      slave_select_error_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Transfer engine
  // ****************************************

  // Sequencer state; disabling the port returns it to idle.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= SPIMS_IDLE;
    end else begin
      case (state_r)
        SPIMS_IDLE: begin
          if ((mst && wr_data) || s_start) begin
            state_r <= SPIMS_RUN;
          end
        end
        SPIMS_RUN: begin
          if (!en || byte_end || slave_select_error_flag_evt) begin
            state_r <= SPIMS_IDLE;
          end
        end
        default: begin
          state_r <= SPIMS_IDLE;
        end
      endcase
    end
  end

  // Shift register and outgoing bit, loaded straight from data writes while idle.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sreg_r <= SPIMS_DATA_RST;
      out_r <= 1'b0;
    end else begin
      if (wr_data && !busy) begin
        sreg_r <= bus_i.wdata;
        out_r <= bus_i.wdata[7];
      end else begin
        if (capture) begin
          sreg_r <= cap_byte;
        end
        if (launch) begin
          out_r <= sreg_r[7];
        end
      end
    end
  end

  // Bit counter for captures.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= 3'h0;
    end else if (!en || slave_select_error_flag_evt || (!busy && !s_start)) begin
      bit_cnt_r <= 3'h0;
    end else if (capture) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Master clock divider and half-period counter.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_r <= 4'h0;
      edge_cnt_r <= 4'h0;
    end else if (!mst || !busy) begin
      div_cnt_r <= {ctrl_r.rate, 1'b1};
      edge_cnt_r <= 4'h0;
    end else if (m_tick) begin
      div_cnt_r <= {ctrl_r.rate, 1'b1};
      edge_cnt_r <= edge_cnt_r + 4'h1;
    end else begin
      div_cnt_r <= div_cnt_r - 4'h1;
    end
  end

  // Receive buffer loads only while the done flag is clear, so it holds the first byte until the flag clears.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rxbuf_r <= SPIMS_DATA_RST;
    end else if (byte_end && !done_r) begin
      rxbuf_r <= end_byte;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************

  // Master drives clock and data out; slave drives its data when selected.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_r <= 1'b0;
      sck_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= mst;
      miso_oe_r <= slv && !ss_s;
      if (m_tick) begin
        sck_r <= !sck_r;
      end else if (!busy) begin
        sck_r <= ctrl_r.cpol;
      end
    end
  end

  assign sck_o = sck_r;
  assign sck_oe_o = sck_oe_r;
  assign mosi_o = out_r;
  assign mosi_oe_o = sck_oe_r;
  assign miso_o = out_r;
  assign miso_oe_o = miso_oe_r;

  // ****************************************
  // Interrupts
  // ****************************************

  // Sticky event bits cleared by writing one; set wins over clear.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ists_r <= SPIMS_IRQ_RST;
      imsk_r <= SPIMS_IRQ_RST;
    end else begin
      ists_r[SPIMS_IRQ_DONE_BIT] <= byte_end
        || (ists_r[SPIMS_IRQ_DONE_BIT] && !(wr_ists && bus_i.wdata[SPIMS_IRQ_DONE_BIT]));
      ists_r[SPIMS_IRQ_MODE_FAULT_FLAG_BIT] <= mode_fault_flag_evt
        || (ists_r[SPIMS_IRQ_MODE_FAULT_FLAG_BIT] && !(wr_ists && bus_i.wdata[SPIMS_IRQ_MODE_FAULT_FLAG_BIT]));
      if (wr_imsk) begin
        imsk_r <= bus_i.wdata[1:0];
      end
    end
  end

  // Request levels and the masked interrupt line.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_req_r <= 1'b0;
      err_req_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      tx_req_r <= done_r;
      err_req_r <= mode_fault_flag_r && !ctrl_r.select_input_disable_bit;
      irq_r <= |(ists_r & imsk_r);
    end
  end

  assign tx_irq_req_o = tx_req_r;
  assign err_irq_req_o = err_req_r;
  assign irq_o = irq_r;

  // ****************************************
  // Read data
  // ****************************************

  // Status view of the flags.
  always_comb begin
    stat = '0;
    stat.transfer_done_flag = done_r;
    stat.write_collision_flag = write_collision_flag_r;
    stat.slave_select_error_flag = slave_select_error_flag_r;
    stat.mode_fault_flag = mode_fault_flag_r;
  end

  // Read data stands in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 8'h00;
    end else if (bus_i.re) begin
      case (bus_i.addr)
        SPIMS_CTRL_ADDR: rdata_r <= ctrl_r;
        SPIMS_STAT_ADDR: rdata_r <= stat;
        SPIMS_DATA_ADDR: rdata_r <= rxbuf_r;
        SPIMS_ISTS_ADDR: rdata_r <= {6'h00, ists_r};
        SPIMS_IMSK_ADDR: rdata_r <= {6'h00, imsk_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_o = rdata_r;

endmodule

// file: verif/spims_asserts.sv
// Checker for the serial port core: bus, link and interrupt relations.
// Assumes it is bound to spims_core and sees only its ports.
`timescale 1ns/1ps
module spims_asserts (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire spims_pkg::spims_bus_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic sck_i,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic mosi_i,
  input wire logic mosi_o,
  input wire logic mosi_oe_o,
  input wire logic miso_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic ss_n_i,
  input wire logic tx_irq_req_o,
  input wire logic err_irq_req_o,
  input wire logic irq_o
);
  import spims_pkg::*;
  // ****
  // Helper state
  // ****
  logic select_input_disable_bit_r;
  logic cpha_r;
  logic sck_q;
  logic [1:0] msk_r;
  logic [3:0] tg_r;
  logic [7:0] cap_r;
  logic [7:0] wr_r;
  // Shadows the software fields and counts serial clock toggles modulo one byte.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      select_input_disable_bit_r <= 1'b0;
      cpha_r <= 1'b0;
      sck_q <= 1'b0;
      msk_r <= 2'h0;
      tg_r <= 4'h0;
      cap_r <= 8'h00;
      wr_r <= 8'h00;
    end else begin
      sck_q <= sck_o;
      if (sck_o != sck_q) tg_r <= tg_r + 4'h1;
      if (sck_o && !sck_q) cap_r <= {cap_r[6:0], mosi_o};
      if (bus_i.we && bus_i.addr == SPIMS_CTRL_ADDR) begin
        select_input_disable_bit_r <= bus_i.wdata[5];
        cpha_r <= bus_i.wdata[3];
      end
      if (bus_i.we && bus_i.addr == SPIMS_IMSK_ADDR) msk_r <= bus_i.wdata[1:0];
      if (bus_i.we && bus_i.addr == SPIMS_DATA_ADDR && tg_r == 4'h0) wr_r <= bus_i.wdata;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_rdata_quiet: assert property (!$past(bus_i.re) |-> rdata_o == 8'h00)
    else $error("read data outside answer");
  chk_err_needs_sel: assert property (ss_n_i [*6] |-> !$rose(err_irq_req_o))
    else $error("error request without select");
  chk_err_gate: assert property (err_irq_req_o |-> !$past(select_input_disable_bit_r))
    else $error("error request with select disabled");
  chk_mode_fault_flag_raise: assert property (
    (sck_oe_o && !select_input_disable_bit_r && !ss_n_i) [*3] |-> ##[0:4] err_irq_req_o)
    else $error("mode fault missed");
  chk_mode_fault_flag_off: assert property ($rose(err_irq_req_o) |-> ##[0:2] !sck_oe_o)
    else $error("port kept enabled");
  chk_done_16: assert property ($rose(tx_irq_req_o) && sck_oe_o |-> tg_r == 4'h0)
    else $error("done not after 16 toggles");
  chk_mosi_byte: assert property (
    $rose(tx_irq_req_o) && sck_oe_o && !cpha_r |-> cap_r == wr_r)
    else $error("sent byte wrong");
  chk_irq_mask: assert property (irq_o |-> $past(msk_r) != 2'h0)
    else $error("masked interrupt");
  cover property ($rose(tx_irq_req_o) && sck_oe_o);
  cover property ($rose(err_irq_req_o));
  cover property ($rose(irq_o));
endmodule
bind spims_core spims_asserts chk_u (.core_clk_i, .nrst_i, .bus_i, .rdata_o, .sck_i, .sck_o,
  .sck_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o, .ss_n_i,
  .tx_irq_req_o, .err_irq_req_o, .irq_o);

// file: verif/spims_slave_model.sv
// Behavioural external slave that answers the core when it is the master.
// Assumes clock polarity 0, phase 0 and a select line driven by the bench.
`timescale 1ns/1ps
module spims_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  input wire logic [7:0] tx_byte_i,
  output logic miso_o,
  output logic [7:0] rx_byte_o = 8'h00
);
  logic [7:0] sh_r = 8'h00;
  logic last_r = 1'b0;
  // Loads the reply on select so its first bit stands before the first edge.
  always @(negedge sel_n_i) sh_r = tx_byte_i;
  // Captures on the leading edge and moves the next bit out on the trailing one.
  always @(posedge sck_i) if (!sel_n_i) rx_byte_o = {rx_byte_o[6:0], mosi_i};
  always @(negedge sck_i) if (!sel_n_i) sh_r = {sh_r[6:0], 1'b0};
  // A released line shows the inverse of its last bit, never a stale copy.
  always @(posedge sel_n_i) last_r = sh_r[7];
  assign miso_o = sel_n_i ? ~last_r : sh_r[7];
endmodule

// file: verif/spims_core_tb.sv
// Self-checking bench for the serial port core in master and slave roles.
// Assumes the slave model and the checker are compiled before it.
`timescale 1ns/1ps
module spims_core_tb;
  import spims_pkg::*;
  localparam logic [7:0] MCTL = 8'hC3;
  localparam int XFER = 32 * (MCTL[2:0] + 1) + 10;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  spims_bus_t bus = '0;
  logic [7:0] rdata, rd_v, p_rx;
  logic [7:0] p_tx = 8'h00;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso, tx_irq, err_irq, irq;
  logic tb_sck = 1'b0;
  logic tb_mosi = 1'b0;
  logic ss_n = 1'b1;
  logic sel_n = 1'b1;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // Wire levels come from whichever party enables its driver.
  wire sck_w = sck_oe ? sck_o : tb_sck;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : p_miso;
  always #2.5 core_clk_i = ~core_clk_i;
  spims_core dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe),
    .ss_n_i(ss_n), .tx_irq_req_o(tx_irq), .err_irq_req_o(err_irq), .irq_o(irq));
  spims_slave_model part_u (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(sel_n),
    .tx_byte_i(p_tx), .miso_o(p_miso), .rx_byte_o(p_rx));
  // ****
  // Tasks
  // ****
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge core_clk_i);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge core_clk_i);
    bus <= '0;
    #1 rd_v = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask
  // Polls status until the done flag shows, bounded.
  task automatic wdone;
    int i;
    rd_v = 8'h00;
    for (i = 0; i < 400 && rd_v[7] !== 1'b1; i++) rd(SPIMS_STAT_ADDR);
    chk(rd_v & 8'h80, 8'h80);
  endtask
  // Acts as an outside master: n bits, m = {polarity, phase}, 64 ns link period.
  // The idle clock level is set 32 ns before the select is driven low; phase 1 keeps select low.
  task automatic link(input logic [7:0] b, input int n, input logic [1:0] m);
    int i;
    tb_sck = m[1];
    #32 ss_n = 1'b0;
    #32;
    for (i = 0; i < n; i++) begin
      if (!m[0]) tb_mosi = b[7-i];
      #16 tb_sck = !m[1];
      if (m[0]) tb_mosi = b[7-i];
      else rd_v[7-i] = miso_w;
      #32 tb_sck = m[1];
      if (m[0]) rd_v[7-i] = miso_w;
      #16;
    end
    if (!m[0]) ss_n = 1'b1;
    #100;
  endtask
  // Cuts a hang short.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      $display("ERROR %0t timeout", $time);
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rc(SPIMS_CTRL_ADDR, SPIMS_CTRL_RST);
    rc(SPIMS_STAT_ADDR, 8'h00);
    rc(SPIMS_DATA_ADDR, SPIMS_DATA_RST);
    wr(8'h10, 8'hFF);
    rc(8'h10, 8'h00);
    $display("test reset done");
    wr(SPIMS_IMSK_ADDR, 8'h03);
    wr(SPIMS_CTRL_ADDR, MCTL);
    p_tx = 8'h3C;
    sel_n = 1'b0;
    wr(SPIMS_DATA_ADDR, 8'hA5);
    repeat (20) @(posedge core_clk_i);
    wr(SPIMS_DATA_ADDR, 8'h77);
    rc(SPIMS_STAT_ADDR, 8'h40);
    chk({7'h00, err_irq}, 8'h00);
    wdone();
    chk({6'h00, tx_irq, irq}, 8'h03);
    sel_n = 1'b1;
    chk(p_rx, 8'hA5);
    rc(SPIMS_DATA_ADDR, 8'h3C);
    rc(SPIMS_STAT_ADDR, 8'h00);
    rc(SPIMS_ISTS_ADDR, 8'h01);
    wr(SPIMS_ISTS_ADDR, 8'h01);
    rc(SPIMS_ISTS_ADDR, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("test master done");
    p_tx = 8'h5A;
    sel_n = 1'b0;
    wr(SPIMS_DATA_ADDR, 8'h11);
    repeat (XFER) @(posedge core_clk_i);
    chk({7'h00, tx_irq}, 8'h01);
    sel_n = 1'b1;
    rc(SPIMS_CTRL_ADDR, MCTL);
    p_tx = 8'hC3;
    sel_n = 1'b0;
    wr(SPIMS_DATA_ADDR, 8'h22);
    repeat (XFER) @(posedge core_clk_i);
    sel_n = 1'b1;
    chk(p_rx, 8'h22);
    rc(SPIMS_DATA_ADDR, 8'h5A);
    rc(SPIMS_STAT_ADDR, 8'h80);
    rc(SPIMS_DATA_ADDR, 8'h5A);
    wr(SPIMS_ISTS_ADDR, 8'h01);
    $display("test overrun done");
    wr(SPIMS_IMSK_ADDR, 8'h01);
    ss_n = 1'b0;
    repeat (8) @(posedge core_clk_i);
    chk({6'h00, err_irq, irq}, 8'h02);
    rc(SPIMS_CTRL_ADDR, 8'h03);
    rc(SPIMS_ISTS_ADDR, 8'h02);
    ss_n = 1'b1;
    rc(SPIMS_STAT_ADDR, 8'h10);
    wr(SPIMS_CTRL_ADDR, 8'h00);
    rc(SPIMS_STAT_ADDR, 8'h00);
    chk({7'h00, err_irq}, 8'h00);
    wr(SPIMS_IMSK_ADDR, 8'h03);
    rc(SPIMS_ISTS_ADDR, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(SPIMS_ISTS_ADDR, 8'h02);
    rc(SPIMS_ISTS_ADDR, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(SPIMS_CTRL_ADDR, 8'hE3);
    ss_n = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rc(SPIMS_STAT_ADDR, 8'h00);
    rc(SPIMS_CTRL_ADDR, 8'hE3);
    ss_n = 1'b1;
    wr(SPIMS_CTRL_ADDR, 8'h00);
    $display("test mode fault done");
    wr(SPIMS_CTRL_ADDR, 8'h80);
    wr(SPIMS_DATA_ADDR, 8'h96);
    link(8'h69, 8, 2'h0);
    chk(rd_v, 8'h96);
    wdone();
    rc(SPIMS_DATA_ADDR, 8'h69);
    rc(SPIMS_STAT_ADDR, 8'h00);
    link(8'hF0, 3, 2'h0);
    rc(SPIMS_STAT_ADDR, 8'h20);
    chk({7'h00, err_irq}, 8'h00);
    wr(SPIMS_CTRL_ADDR, 8'h00);
    rc(SPIMS_STAT_ADDR, 8'h00);
    $display("test slave done");
    wr(SPIMS_CTRL_ADDR, 8'h98);
    wr(SPIMS_DATA_ADDR, 8'h5A);
    link(8'hC6, 8, 2'h3);
    chk(rd_v, 8'h5A);
    wdone();
    rc(SPIMS_DATA_ADDR, 8'hC6);
    link(8'h3B, 8, 2'h3);
    ss_n = 1'b1;
    chk(rd_v, 8'hC6);
    wdone();
    rc(SPIMS_DATA_ADDR, 8'h3B);
    rc(SPIMS_STAT_ADDR, 8'h00);
    wr(SPIMS_CTRL_ADDR, 8'h00);
    $display("test phase one done");
    end_sim();
  end
endmodule
